// >>> pkg/dca_regs.vh
`ifndef DCA_REGS_VH
`define DCA_REGS_VH
// Command codes {cs_n, ras_n, cas_n, we_n}
`define DCA_CMD_MRS    4'h0
`define DCA_CMD_REF    4'h1
`define DCA_CMD_PRE    4'h2
`define DCA_CMD_ACT    4'h3
`define DCA_CMD_WR     4'h4
`define DCA_CMD_ZQC    4'h6
`define DCA_CMD_RD     4'h5
`define DCA_CMD_NOP    4'h7
// Address field positions
`define DCA_AP_BIT     10
`define DCA_BC_BIT     12
// Power states
`define DCA_ST_IDLE    2'h0
`define DCA_ST_APD     2'h1
`define DCA_ST_PPD     2'h2
`define DCA_ST_SR      2'h3
`define DCA_BANKS      8
`endif

// >>> rtl/dca_cmd_inputs.v
// What this block does
// - All address and control inputs are sampled only on the rising clock edge.
// - CKE high runs internal clocks, buffers, drivers; low turns them off.
// - CKE low gives precharge power-down or self-refresh idle, else active power-down.
// - CKE synchronous for power-down entry/exit, SR entry; SR exit also sampled on the rising edge.
// - In power-down all input buffers off except clocks, ODT and CKE.
// - In self-refresh all input buffers off except CKE.
// - Commands with chip select sampled high are ignored.
// - Command decoded from RAS, CAS, WE together with chip select.
// - Write beats with data mask high are left unwritten, mask on both strobe edges.
// - On x8 parts the shared pin is mask or termination strobe, per MR1 bit.
// - Bit set gives strobe-like termination on TDQS; clear gives mask; x16 uses zero.
// - Bank address selects target bank, or the mode register during MRS.
// - On read/write, A10 high requests auto-precharge; low leaves row open.
// - On precharge, A10 low closes selected bank; high closes all banks.
// - Address carries row at activate, column at read/write, opcode at MRS.
// - On read/write, A12 low chops the burst; high gives full burst.
// - ODT high enables termination on DQ, DQS, DQS#, DM/TDQS pins.
// - ODT is ignored when MR1 and MR2 both disable termination.
`timescale 1ns/1ps
`default_nettype none
`include "dca_regs.vh"
module dca_cmd_inputs #(
  parameter X16   = 0,
  parameter AW    = 14,
  parameter MSKW  = 2
) (
  input  wire            REF_CLK_I,     // Device clock
  input  wire            RST_N_I,       // Sync reset, active low
  input  wire            CKE_I,         // Clock enable
  input  wire            SR_REQ_I,      // Self-refresh entry on CKE fall
  input  wire            CS_N_I,        // Chip select
  input  wire            RAS_N_I,       // Row strobe
  input  wire            CAS_N_I,       // Column strobe
  input  wire            WE_N_I,        // Write enable
  input  wire [2:0]      BA_I,          // Bank address
  input  wire [AW-1:0]   ADDR_I,        // Address
  input  wire            ODT_I,         // Termination enable
  input  wire [MSKW-1:0] DM_I,          // Data mask per lane
  input  wire            WBEAT_I,       // Write beat, either strobe edge
  input  wire            MR1_TDQS_I,    // MR1 termination strobe select
  input  wire            MR1_RTT_EN_I,  // MR1 termination enabled
  input  wire            MR2_RTT_EN_I,  // MR2 termination enabled
  output reg             ICLK_EN_O,     // Internal clocks and drivers on
  output reg             BUF_CA_EN_O,   // Command/address buffers on
  output reg             BUF_CK_EN_O,   // Clock and ODT buffers on
  output reg  [1:0]      PWR_ST_O,      // Power state
  output reg  [3:0]      CMD_O,         // Decoded command
  output reg             CMD_VLD_O,     // Command pulse
  output reg  [2:0]      BANK_O,        // Target bank or mode register
  output reg  [AW-1:0]   ROW_O,         // Row address at activate
  output reg  [9:0]      COL_O,         // Column at read/write
  output reg  [AW-1:0]   OPCODE_O,      // Mode register opcode
  output reg             AUTO_PRE_O,    // Auto-precharge requested
  output reg             PRE_ALL_O,     // Precharge all banks
  output reg             CHOP_O,        // Burst chopped
  output reg  [7:0]      OPEN_BANKS_O,  // Banks with open row
  output reg  [MSKW-1:0] BEAT_WR_EN_O,  // Per-lane beat write enable
  output reg             TDQS_MODE_O,   // Shared pin is term strobe
  output reg             ODT_ON_O       // Termination active
);
  // ----------------------------------------
  // Local state and decode
  // ----------------------------------------
  reg  [1:0]            st_q;
  reg  [`DCA_BANKS-1:0] open_q;
  reg                   cke_q;
  wire [3:0]            cmd;
  wire                  ca_live;
  wire                  ck_live;
  wire                  tdqs;
  wire                  rtt_en;
  wire                  take;
  wire                  take_act;
  wire                  take_rw;
  wire                  take_pre;
  wire                  take_mrs;
  wire                  ap_bit;
  wire [MSKW-1:0]       lane_wr;

  // Read or write column access
  function f_is_rw;
    input [3:0] code;
    begin
      f_is_rw = (code == `DCA_CMD_RD) || (code == `DCA_CMD_WR);
    end
  endfunction

  // Strobe mode turns the mask pin into a termination strobe
  function f_mask_ok;
    input beat;
    input mask;
    input strobe_mode;
    begin
      f_mask_ok = beat && !(mask && !strobe_mode);
    end
  endfunction

  assign cmd      = {CS_N_I, RAS_N_I, CAS_N_I, WE_N_I};
  assign ca_live  = (st_q == `DCA_ST_IDLE);
  assign ck_live  = (st_q != `DCA_ST_SR);
  assign tdqs     = (X16 == 0) && MR1_TDQS_I;
  assign rtt_en   = MR1_RTT_EN_I || MR2_RTT_EN_I;
  assign take     = ca_live && CKE_I && cke_q && !CS_N_I && (cmd != `DCA_CMD_NOP);
  assign take_act = take && (cmd == `DCA_CMD_ACT);
  assign take_rw  = take && f_is_rw(cmd);
  assign take_pre = take && (cmd == `DCA_CMD_PRE);
  assign take_mrs = take && (cmd == `DCA_CMD_MRS);
  assign ap_bit   = ADDR_I[`DCA_AP_BIT];

  // ----------------------------------------
  // Per-lane write mask
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < MSKW; g = g + 1) begin : g_lane
      if ((X16 != 0) || (g == 0)) begin : g_used
        assign lane_wr[g] = f_mask_ok(WBEAT_I, DM_I[g], tdqs);
      end else begin : g_unused
        // An x8 part has no upper lane
        assign lane_wr[g] = 1'b0;
      end
    end
  endgenerate

  // ----------------------------------------
  // Power state
  // ----------------------------------------
  always @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      st_q  <= `DCA_ST_IDLE;
      cke_q <= 1'b1;
    end else begin
      cke_q <= CKE_I;
      case (st_q)
        `DCA_ST_IDLE: begin
          if (!CKE_I)
            st_q <= (open_q != 8'h00) ? `DCA_ST_APD :
                    (SR_REQ_I ? `DCA_ST_SR : `DCA_ST_PPD);
        end
        `DCA_ST_APD, `DCA_ST_PPD: begin
          if (CKE_I)
            st_q <= `DCA_ST_IDLE;
        end
        `DCA_ST_SR: begin
          // level exit, no clock qualifier beyond sampling
          if (CKE_I)
            st_q <= `DCA_ST_IDLE;
        end
        default: st_q <= `DCA_ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Command capture and decode
  // ----------------------------------------
  // code latched on rising edge only
  always @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      CMD_O     <= `DCA_CMD_NOP;
      CMD_VLD_O <= 1'b0;
    end else begin
      CMD_VLD_O <= take;
      if (take) begin
        CMD_O <= cmd;
      end
    end
  end

  always @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      BANK_O <= 3'h0;
    end else if (take) begin
      BANK_O <= BA_I;
    end
  end

  always @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      ROW_O <= {AW{1'b0}};
    end else if (take_act) begin
      ROW_O <= ADDR_I;
    end
  end

  always @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      COL_O <= 10'h000;
    end else if (take_rw) begin
      COL_O <= ADDR_I[9:0];
    end
  end

  always @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      OPCODE_O <= {AW{1'b0}};
    end else if (take_mrs) begin
      OPCODE_O <= ADDR_I;
    end
  end

  always @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      AUTO_PRE_O <= 1'b0;
      PRE_ALL_O  <= 1'b0;
    end else begin
      AUTO_PRE_O <= take_rw && ap_bit;
      PRE_ALL_O  <= take_pre && ap_bit;
    end
  end

  always @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      CHOP_O <= 1'b0;
    end else if (take_rw) begin
      CHOP_O <= ~ADDR_I[`DCA_BC_BIT];
    end
  end

  // open rows; auto-precharge closes at once, not after the burst
  always @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      open_q <= {`DCA_BANKS{1'b0}};
    end else if (take_act) begin
      open_q[BA_I] <= 1'b1;
    end else if (take_pre && ap_bit) begin
      open_q <= {`DCA_BANKS{1'b0}};
    end else if (take_pre || (take_rw && ap_bit)) begin
      open_q[BA_I] <= 1'b0;
    end
  end

  // ----------------------------------------
  // Buffers, mask and termination
  // ----------------------------------------
  // clocks follow the enable
  always @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      ICLK_EN_O <= 1'b0;
    end else begin
      ICLK_EN_O <= CKE_I && ca_live;
    end
  end

  // clock and ODT kept in power-down only
  always @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      BUF_CA_EN_O <= 1'b0;
      BUF_CK_EN_O <= 1'b0;
    end else begin
      BUF_CA_EN_O <= ca_live;
      BUF_CK_EN_O <= ck_live;
    end
  end

  always @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      PWR_ST_O     <= `DCA_ST_IDLE;
      OPEN_BANKS_O <= 8'h00;
    end else begin
      PWR_ST_O     <= st_q;
      OPEN_BANKS_O <= open_q;
    end
  end

  always @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      TDQS_MODE_O <= 1'b0;
    end else begin
      TDQS_MODE_O <= tdqs;
    end
  end

  always @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      BEAT_WR_EN_O <= {MSKW{1'b0}};
    end else begin
      BEAT_WR_EN_O <= lane_wr;
    end
  end

  always @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      ODT_ON_O <= 1'b0;
    end else begin
      ODT_ON_O <= ODT_I && rtt_en && ck_live;
    end
  end
endmodule // dca_cmd_inputs
`default_nettype wire

// >>> bench/dca_cmd_inputs_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "dca_regs.vh"
module dca_cmd_chk #(parameter AW = 14) (
  input wire logic          REF_CLK_I, RST_N_I, CKE_I,         // Clock, reset, enable
  input wire logic          CS_N_I, RAS_N_I, CAS_N_I, WE_N_I,  // Command pins
  input wire logic [AW-1:0] ADDR_I,                            // Address
  input wire logic [3:0]    CMD_O,                             // Decoded command
  input wire logic          CMD_VLD_O, AUTO_PRE_O, PRE_ALL_O,  // Command pulses
  input wire logic          CHOP_O, ICLK_EN_O                  // Chop, clocks on
);
  wire logic [3:0] code = {CS_N_I, RAS_N_I, CAS_N_I, WE_N_I};
  wire logic rw = CMD_VLD_O && (CMD_O == `DCA_CMD_RD || CMD_O == `DCA_CMD_WR);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_N_I);
  sequence s_cke_off; !CKE_I [*3]; endsequence
  property p_cs_mask; CS_N_I |=> !CMD_VLD_O; endproperty
  a_cs_mask: assert property (p_cs_mask) else $error("masked command taken");
  property p_nop; code == `DCA_CMD_NOP |=> !CMD_VLD_O; endproperty
  a_nop: assert property (p_nop) else $error("no-op gave a command");
  property p_cke; !CKE_I |=> !CMD_VLD_O; endproperty
  a_cke: assert property (p_cke) else $error("command taken with clock enable low");
  property p_code; CMD_VLD_O |-> CMD_O == $past(code); endproperty
  a_code: assert property (p_code) else $error("command decoded wrongly");
  property p_ap; rw |-> AUTO_PRE_O == $past(ADDR_I[`DCA_AP_BIT]); endproperty
  a_ap: assert property (p_ap) else $error("auto-precharge flag wrong");
  property p_pall; CMD_VLD_O && CMD_O == `DCA_CMD_PRE |-> PRE_ALL_O == $past(ADDR_I[10]); endproperty
  a_pall: assert property (p_pall) else $error("precharge-all flag wrong");
  property p_chop; rw |-> CHOP_O == !$past(ADDR_I[`DCA_BC_BIT]); endproperty
  a_chop: assert property (p_chop) else $error("burst chop flag wrong");
  property p_iclk; s_cke_off |-> !ICLK_EN_O; endproperty
  a_iclk: assert property (p_iclk) else $error("internal clocks on while disabled");
endmodule // dca_cmd_chk
bind dca_cmd_inputs dca_cmd_chk #(.AW(AW)) dca_cmd_chk_inst (.REF_CLK_I(REF_CLK_I),
  .RST_N_I(RST_N_I), .CKE_I(CKE_I), .CS_N_I(CS_N_I), .RAS_N_I(RAS_N_I), .CAS_N_I(CAS_N_I),
  .WE_N_I(WE_N_I), .ADDR_I(ADDR_I), .CMD_O(CMD_O), .CMD_VLD_O(CMD_VLD_O),
  .AUTO_PRE_O(AUTO_PRE_O), .PRE_ALL_O(PRE_ALL_O), .CHOP_O(CHOP_O), .ICLK_EN_O(ICLK_EN_O));
`default_nettype wire

// >>> bench/dca_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "dca_regs.vh"
module dca_ctrl_model (
  input  wire logic       clk_i,   // Clock
  output var  logic       cke_o,   // Clock enable
  output var  logic [3:0] ca_o,    // Chip select, row, column, write
  output var  logic [2:0] ba_o,    // Bank
  output var  logic [13:0] addr_o  // Address
);
  initial begin
    cke_o = 1'b1;
    ca_o = `DCA_CMD_NOP;
    ba_o = 3'h0;
    addr_o = 14'h0;
  end
  // enable never dropped inside an access
  task issue(input logic [3:0] c, input logic [2:0] b, input logic [13:0] a);
    @(posedge clk_i);
    ca_o <= c;
    ba_o <= b;
    addr_o <= a;
    @(posedge clk_i);
    ca_o <= `DCA_CMD_NOP;
    // Released bus shows junk, not the old address
    addr_o <= ~a;
    #1;
  endtask
  task set_cke(input logic v);
    @(posedge clk_i);
    cke_o <= v;
  endtask
endmodule // dca_ctrl_model
`default_nettype wire

// >>> bench/dca_cmd_inputs_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "dca_regs.vh"
module dca_cmd_inputs_tb;
  logic clk, rst_n, sr, odt, wb, tdqs, r1, r2;
  logic [1:0] dm;
  wire logic cke, iclk, bca, bck, vld, ap, pall, chop, tm, odt_on;
  wire logic [3:0] ca, dc;
  wire logic [2:0] ba, bank;
  wire logic [1:0] pst, wen;
  wire logic [13:0] addr, row, opc;
  wire logic [9:0] col;
  wire logic [7:0] obk;
  int n_mismatch, checks_done;
  dca_ctrl_model dca_ctrl_model_inst (.clk_i(clk), .cke_o(cke), .ca_o(ca), .ba_o(ba), .addr_o(addr));
  dca_cmd_inputs dca_cmd_inputs_inst (.REF_CLK_I(clk), .RST_N_I(rst_n), .CKE_I(cke), .SR_REQ_I(sr),
    .CS_N_I(ca[3]), .RAS_N_I(ca[2]), .CAS_N_I(ca[1]), .WE_N_I(ca[0]), .BA_I(ba), .ADDR_I(addr),
    .ODT_I(odt), .DM_I(dm), .WBEAT_I(wb), .MR1_TDQS_I(tdqs), .MR1_RTT_EN_I(r1), .MR2_RTT_EN_I(r2),
    .ICLK_EN_O(iclk), .BUF_CA_EN_O(bca), .BUF_CK_EN_O(bck), .PWR_ST_O(pst), .CMD_O(dc),
    .CMD_VLD_O(vld), .BANK_O(bank), .ROW_O(row), .COL_O(col), .OPCODE_O(opc), .AUTO_PRE_O(ap),
    .PRE_ALL_O(pall), .CHOP_O(chop), .OPEN_BANKS_O(obk), .BEAT_WR_EN_O(wen), .TDQS_MODE_O(tm),
    .ODT_ON_O(odt_on));
  task chk(input logic [63:0] n, input logic [13:0] e, input logic [13:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %0s expected %h seen %h", n, e, g);
    end
  endtask
  task iss(input logic [3:0] c, input logic [2:0] b, input logic [13:0] a);
    dca_ctrl_model_inst.issue(c, b, a);
  endtask
  task step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task beat(input logic [1:0] d);
    @(posedge clk) begin dm <= d; wb <= 1'b1; end
    @(posedge clk) wb <= 1'b0;
    #1;
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin clk = 0; forever #12.5 clk = ~clk; end
  // Whole run is about a hundred cycles
  initial begin #40000; n_mismatch++; close_out; end
  initial begin
    {rst_n, sr, odt, wb, tdqs, r1, r2, dm} = 9'h0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    step(2);
    for (int c = 0; c < 8; c++) begin
      iss(c[3:0], 3'h0, 14'h0);
      chk("vld", c != 7, vld); if (c != 7) chk("cmd", c[3:0], dc);
    end
    $display("test codes done");
    iss(`DCA_CMD_ACT, 3'h2, 14'h1ABC); chk("bank", 3'h2, bank); chk("row", 14'h1ABC, row);
    step(1); chk("open2", 1, obk[2]);
    iss(`DCA_CMD_RD, 3'h2, 14'h0655); chk("ap", 1, ap); chk("chop", 1, chop); chk("col", 10'h255, col);
    iss(`DCA_CMD_WR, 3'h0, 14'h1003); chk("ap", 0, ap); chk("chop", 0, chop);
    iss(`DCA_CMD_ACT, 3'h5, 14'h0); iss(`DCA_CMD_PRE, 3'h0, 14'h0400); chk("pall", 1, pall);
    iss(`DCA_CMD_ACT, 3'h5, 14'h0); iss(`DCA_CMD_ACT, 3'h1, 14'h0);
    iss(`DCA_CMD_PRE, 3'h5, 14'h0); chk("pall", 0, pall); step(1); chk("open", 8'h02, obk);
    iss(`DCA_CMD_PRE, 3'h0, 14'h0400);
    iss(`DCA_CMD_MRS, 3'h1, 14'h0246); chk("mr", 3'h1, bank); chk("op", 14'h0246, opc);
    iss(4'hB, 3'h3, 14'h0); chk("vld", 0, vld);
    $display("test fields done");
    @(posedge clk) sr <= 1'b1;
    dca_ctrl_model_inst.set_cke(1'b0); step(4); chk("pst", `DCA_ST_SR, pst);
    chk("bca", 0, bca); chk("bck", 0, bck); chk("iclk", 0, iclk);
    dca_ctrl_model_inst.set_cke(1'b1); step(3); chk("pst", `DCA_ST_IDLE, pst);
    chk("iclk", 1, iclk); chk("bca", 1, bca); chk("bck", 1, bck);
    @(posedge clk) sr <= 1'b0;
    dca_ctrl_model_inst.set_cke(1'b0); step(4); chk("pst", `DCA_ST_PPD, pst);
    chk("bck", 1, bck); chk("bca", 0, bca);
    dca_ctrl_model_inst.set_cke(1'b1); step(3); iss(`DCA_CMD_ACT, 3'h4, 14'h0);
    dca_ctrl_model_inst.set_cke(1'b0); step(4); chk("pst", `DCA_ST_APD, pst);
    dca_ctrl_model_inst.set_cke(1'b1); step(3);
    $display("test power done");
    beat(2'b01); chk("wen", 2'b00, wen);
    beat(2'b10); chk("wen", 2'b01, wen);
    @(posedge clk) tdqs <= 1'b1;
    beat(2'b01); chk("wen", 2'b01, wen); chk("tdqs", 1, tm);
    $display("test mask done");
    @(posedge clk) begin odt <= 1'b1; r1 <= 1'b1; end
    step(2); chk("odt", 1, odt_on);
    @(posedge clk) r1 <= 1'b0;
    step(2); chk("odt", 0, odt_on);
    @(posedge clk) r2 <= 1'b1;
    step(2); chk("odt", 1, odt_on);
    $display("test termination done");
    close_out;
  end
endmodule // dca_cmd_inputs_tb
`default_nettype wire
